// ===== logic/liusp_pkg.sv
package liusp_pkg;

	// ---------------------------------------------------------------
	// Edge select encodings
	// ---------------------------------------------------------------
	localparam logic RX_EDGE_RISE  = 1'h0;
	localparam logic TX_EDGE_FALL  = 1'h0;
	localparam logic SP_IN_RISE    = 1'h0;
	localparam logic SP_OUT_FALL   = 1'h0;

	// Reset value of every control bit
	localparam logic CTRL_RESET    = 1'h0;

	// ---------------------------------------------------------------
	// Transmit clock sources
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LIUSP_TXSRC_PIN  = 2'h0,
		LIUSP_TXSRC_MCLK = 2'h1,
		LIUSP_TXSRC_RCLK = 2'h2
	} liusp_txsrc_e;

	// Control bits as one carrier
	typedef struct packed {
		logic         rx_edge_select_bit;
		logic         tx_edge_select_bit;
		logic         nrz_enable_bit;
		liusp_txsrc_e tx_clock_source;
	} liusp_ctrl_s;

	// Receive symbol from the line decoder
	typedef struct packed {
		logic pos;
		logic neg;
		logic err;
	} liusp_rxsym_s;

	// Edge detector state for a sampled clock
	typedef enum logic [1:0] {
		LIUSP_EDGE_NONE,
		LIUSP_EDGE_RISE,
		LIUSP_EDGE_FALL
	} liusp_edge_e;

	// Edge kind from previous and current clock level
	function automatic liusp_edge_e liusp_edge(input logic prev, input logic cur);
		if (!prev && cur)
			return LIUSP_EDGE_RISE;
		if (prev && !cur)
			return LIUSP_EDGE_FALL;
		return LIUSP_EDGE_NONE;
	endfunction

endpackage

// ===== logic/liusp_pin_drv.sv
module liusp_pin_drv
	import liusp_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Control
	input  wire logic             tristate_test,
	input  wire logic [WIDTH-1:0] value_d,
	// Pins
	output logic      [WIDTH-1:0] pin_o,
	output logic      [WIDTH-1:0] pin_oe_n
);

	// Registered pin values and 3-state enables
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_o    <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_o    <= value_d;
			pin_oe_n <= {WIDTH{tristate_test}};
		end
	end

endmodule // liusp_pin_drv

// ===== logic/liusp_port.sv
module liusp_port
	import liusp_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         hardware_reset_n,
	// Control
	input  wire liusp_ctrl_s  ctrl_wr_data,
	input  wire logic         ctrl_wr,
	input  wire logic         input_edge_select,
	input  wire logic         output_edge_select,
	input  wire logic         tristate_test,
	// Sampled clocks
	input  wire logic         recovered_clock,
	input  wire logic         master_clock,
	input  wire logic         transmit_clock_in,
	input  wire logic         serial_clock,
	// Receive side from decoder
	input  wire liusp_rxsym_s rx_symbol,
	// Transmit pins
	input  wire logic         tx_positive_data,
	input  wire logic         tx_negative_data,
	// Serial port data
	input  wire logic         serial_port_data_in,
	input  wire logic         sp_out_bit,
	// Receive and serial output pins
	output logic              rx_positive_data,
	output logic              rx_negative_data,
	output logic              rx_positive_data_oe_n,
	output logic              rx_negative_data_oe_n,
	output logic              serial_port_data_out,
	output logic              serial_port_data_out_oe_n,
	// To formatter and serial engine
	output logic              tx_pos_q,
	output logic              tx_neg_q,
	output logic              tx_strobe_q,
	output logic              sp_in_bit_q,
	output logic              sp_in_strobe_q,
	output liusp_ctrl_s       ctrl_q
);

	// ---------------------------------------------------------------
	// Control bits
	// ---------------------------------------------------------------
	logic        rclk_q;
	logic        mclk_q;
	logic        transmit_clock_in_q;
	logic        sclk_q;
	logic        txclk_sel;
	logic        txclk_sel_q;
	logic        rx_upd;
	logic        tx_smp;
	logic        sp_smp;
	logic        sp_lau;
	logic        rx_pos_q;
	logic        rx_neg_q;
	logic        sdo_d;
	logic        sdo_q;
	liusp_edge_e rx_edge;
	liusp_edge_e tx_edge;
	liusp_edge_e sp_edge;

	// Control register with reset to zero
	always_ff @(posedge core_clk) begin
		if (!rst_n || !hardware_reset_n)
			ctrl_q <= '{CTRL_RESET, CTRL_RESET, CTRL_RESET, LIUSP_TXSRC_PIN};
		else if (ctrl_wr)
			ctrl_q <= ctrl_wr_data;
	end

	// ---------------------------------------------------------------
	// Clock edge detection
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rclk_q      <= 1'h0;
			mclk_q      <= 1'h0;
			transmit_clock_in_q      <= 1'h0;
			sclk_q      <= 1'h0;
			txclk_sel_q <= 1'h0;
		end else begin
			rclk_q      <= recovered_clock;
			mclk_q      <= master_clock;
			transmit_clock_in_q      <= transmit_clock_in;
			sclk_q      <= serial_clock;
			txclk_sel_q <= txclk_sel;
		end
	end

	// Transmit clock source selection
	always_comb begin
		case (ctrl_q.tx_clock_source)
			LIUSP_TXSRC_MCLK: txclk_sel = mclk_q;
			LIUSP_TXSRC_RCLK: txclk_sel = rclk_q;
			default:          txclk_sel = transmit_clock_in_q;
		endcase
	end

	assign rx_edge = liusp_edge(rclk_q, recovered_clock);
	assign tx_edge = liusp_edge(txclk_sel_q, txclk_sel);
	assign sp_edge = liusp_edge(sclk_q, serial_clock);

	// Selected edge strobes
	assign rx_upd = (ctrl_q.rx_edge_select_bit == RX_EDGE_RISE) ?
		(rx_edge == LIUSP_EDGE_RISE) : (rx_edge == LIUSP_EDGE_FALL);
	assign tx_smp = (ctrl_q.tx_edge_select_bit == TX_EDGE_FALL) ?
		(tx_edge == LIUSP_EDGE_FALL) : (tx_edge == LIUSP_EDGE_RISE);
	assign sp_smp = (input_edge_select == SP_IN_RISE) ?
		(sp_edge == LIUSP_EDGE_RISE) : (sp_edge == LIUSP_EDGE_FALL);
	assign sp_lau = (output_edge_select == SP_OUT_FALL) ?
		(sp_edge == LIUSP_EDGE_FALL) : (sp_edge == LIUSP_EDGE_RISE);

	// ---------------------------------------------------------------
	// Receive data path
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_pos_q <= 1'h0;
			rx_neg_q <= 1'h0;
		end else if (rx_upd) begin
			rx_pos_q <= rx_symbol.pos;
			rx_neg_q <= ctrl_q.nrz_enable_bit ? rx_symbol.err : rx_symbol.neg;
		end
	end

	// Serial output launch
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			sdo_q <= 1'h0;
		else if (sp_lau)
			sdo_q <= sp_out_bit;
	end
	assign sdo_d = sdo_q;

	// Registered pins with test 3-state
	liusp_pin_drv #(
		.WIDTH(3)
	) u_pins (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.tristate_test (tristate_test),
		.value_d       ({rx_pos_q, rx_neg_q, sdo_d}),
		.pin_o         ({rx_positive_data, rx_negative_data, serial_port_data_out}),
		.pin_oe_n      ({rx_positive_data_oe_n, rx_negative_data_oe_n,
			serial_port_data_out_oe_n})
	);

	// ---------------------------------------------------------------
	// Transmit and serial input sampling
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_pos_q    <= 1'h0;
			tx_neg_q    <= 1'h0;
			tx_strobe_q <= 1'h0;
		end else begin
			tx_strobe_q <= tx_smp;
			if (tx_smp) begin
				tx_pos_q <= tx_positive_data;
				tx_neg_q <= tx_negative_data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sp_in_bit_q    <= 1'h0;
			sp_in_strobe_q <= 1'h0;
		end else begin
			sp_in_strobe_q <= sp_smp;
			if (sp_smp)
				sp_in_bit_q <= serial_port_data_in;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_rx_update;
		@(posedge core_clk) disable iff (!rst_n)
		rx_upd |=> ##1 (rx_positive_data == $past(rx_symbol.pos, 2));
	endproperty
	a_rx_update: assert property (p_rx_update) else $error("rx data not updated");

	property p_nrz_err;
		@(posedge core_clk) disable iff (!rst_n)
		(rx_upd && ctrl_q.nrz_enable_bit && rx_symbol.err) |=> ##1 rx_negative_data;
	endproperty
	a_nrz_err: assert property (p_nrz_err) else $error("nrz error pulse missing");

	property p_bip_neg;
		@(posedge core_clk) disable iff (!rst_n)
		(rx_upd && !ctrl_q.nrz_enable_bit) |=> ##1 (rx_negative_data == $past(rx_symbol.neg, 2));
	endproperty
	a_bip_neg: assert property (p_bip_neg) else $error("bipolar neg wrong");

	property p_rx_hold;
		@(posedge core_clk) disable iff (!rst_n)
		!rx_upd |=> ##1 $stable(rx_positive_data);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx data moved off edge");

	property p_tx_sample;
		@(posedge core_clk) disable iff (!rst_n)
		tx_smp |=> (tx_pos_q == $past(tx_positive_data))
			&& (tx_neg_q == $past(tx_negative_data)) && tx_strobe_q;
	endproperty
	a_tx_sample: assert property (p_tx_sample) else $error("tx not sampled");

	property p_sp_in;
		@(posedge core_clk) disable iff (!rst_n)
		sp_smp |=> (sp_in_bit_q == $past(serial_port_data_in)) && sp_in_strobe_q;
	endproperty
	a_sp_in: assert property (p_sp_in) else $error("serial in not sampled");

	property p_sp_out;
		@(posedge core_clk) disable iff (!rst_n)
		sp_lau |=> ##1 (serial_port_data_out == $past(sp_out_bit, 2));
	endproperty
	a_sp_out: assert property (p_sp_out) else $error("serial out not launched");

	property p_tristate;
		@(posedge core_clk) disable iff (!rst_n)
		tristate_test |=> (rx_positive_data_oe_n && rx_negative_data_oe_n
			&& serial_port_data_out_oe_n);
	endproperty
	a_tristate: assert property (p_tristate) else $error("pins not floated");

	// Sampled reset in the antecedent skips the release edge
	property p_drive;
		@(posedge core_clk) disable iff (!rst_n)
		(rst_n && !tristate_test) |=> !(rx_positive_data_oe_n || rx_negative_data_oe_n
			|| serial_port_data_out_oe_n);
	endproperty
	a_drive: assert property (p_drive) else $error("pins not driven");

	property p_hw_reset;
		@(posedge core_clk) disable iff (!rst_n)
		!hardware_reset_n |=> (ctrl_q == '0);
	endproperty
	a_hw_reset: assert property (p_hw_reset) else $error("control not cleared");

	c_nrz_err:  cover property (@(posedge core_clk) disable iff (!rst_n)
		rx_upd && ctrl_q.nrz_enable_bit && rx_symbol.err);
	c_tx_rclk:  cover property (@(posedge core_clk) disable iff (!rst_n)
		tx_smp && ctrl_q.tx_clock_source == LIUSP_TXSRC_RCLK);
	c_sp_fall:  cover property (@(posedge core_clk) disable iff (!rst_n)
		sp_smp && input_edge_select);

endmodule // liusp_port

// ===== tb/liusp_framer_model.sv
module liusp_framer_model (
	// Clock and control
	input  wire logic core_clk,
	input  wire logic run,
	input  wire logic edge_sel,
	// Transmit pins
	output logic      transmit_clock_in = 1'h0,
	output logic      tx_positive_data,
	output logic      tx_negative_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q = 2'h0;
	logic [1:0] pat_q = 2'h0;

	// Line clock, stands still outside frames
	always_ff @(posedge core_clk) begin
		div_q <= run ? div_q + 2'h1 : 2'h0;
		if (run && div_q == 2'h3)
			transmit_clock_in <= ~transmit_clock_in;
	end

	// Data launched on the edge away from sampling, churns while idle
	always_ff @(posedge core_clk) begin
		if (!run)
			pat_q <= ~pat_q;
		else if (div_q == 2'h3 && transmit_clock_in == edge_sel)
			pat_q <= pat_q + 2'h1;
	end
	assign tx_positive_data = pat_q[0];
	assign tx_negative_data = pat_q[1];
endmodule // liusp_framer_model

// ===== tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import liusp_pkg::*;
	logic         core_clk = 1'h0, rst_n = 1'h0, hardware_reset_n = 1'h1;
	logic         ctrl_wr = 1'h0, tristate_test = 1'h0, run = 1'h0;
	logic         input_edge_select = 1'h0, output_edge_select = 1'h0;
	logic         serial_port_data_in = 1'h0, sp_out_bit = 1'h0, nxt_sdi, nxt_sob;
	logic [2:0]   clks = 3'h0;
	liusp_ctrl_s  ctrl_wr_data = '0, ctrl_q;
	liusp_rxsym_s rx_symbol = '0, nxt_sym;
	logic         transmit_clock_in, tx_positive_data, tx_negative_data, sp_bit;
	logic         rx_positive_data, rx_negative_data, serial_port_data_out;
	logic         rx_positive_data_oe_n, rx_negative_data_oe_n, serial_port_data_out_oe_n;
	logic         tx_pos_q, tx_neg_q, tx_strobe_q, sp_in_bit_q, sp_in_strobe_q;
	int           bad_count = 0, checks_done = 0, n_tx, n_sp;

	always #2 core_clk = ~core_clk;

	liusp_port liusp_port_i (.core_clk, .rst_n, .hardware_reset_n, .ctrl_wr_data, .ctrl_wr,
		.input_edge_select, .output_edge_select, .tristate_test, .recovered_clock(clks[0]),
		.master_clock(clks[1]), .transmit_clock_in, .serial_clock(clks[2]), .rx_symbol,
		.tx_positive_data, .tx_negative_data, .serial_port_data_in, .sp_out_bit,
		.rx_positive_data, .rx_negative_data, .rx_positive_data_oe_n, .rx_negative_data_oe_n,
		.serial_port_data_out, .serial_port_data_out_oe_n, .tx_pos_q, .tx_neg_q, .tx_strobe_q,
		.sp_in_bit_q, .sp_in_strobe_q, .ctrl_q);

	liusp_framer_model liusp_framer_model_i (.core_clk, .run,
		.edge_sel(ctrl_wr_data.tx_edge_select_bit), .transmit_clock_in, .tx_positive_data,
		.tx_negative_data);

	task automatic check(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Move one sampled clock with new data, then watch four cycles
	task automatic edge_to(input int idx, input logic lvl);
		n_tx = 0;
		n_sp = 0;
		@(posedge core_clk) begin
			clks[idx] <= lvl;
			rx_symbol <= nxt_sym;
			serial_port_data_in <= nxt_sdi;
			sp_out_bit <= nxt_sob;
		end
		repeat (4) begin
			@(posedge core_clk) #1;
			n_tx += int'(tx_strobe_q);
			if (sp_in_strobe_q === 1'h1) begin
				n_sp++;
				sp_bit = sp_in_bit_q;
			end
		end
	endtask

	task automatic set_ctrl(input logic rx, tx, nrz, input liusp_txsrc_e src);
		@(posedge core_clk) begin
			ctrl_wr <= 1'h1;
			ctrl_wr_data <= {rx, tx, nrz, src};
		end
		@(posedge core_clk) ctrl_wr <= 1'h0;
		@(posedge core_clk) #1;
		check("ctrl", {3'h0, ctrl_q}, {3'h0, rx, tx, nrz, src});
	endtask

	// Hardware reset clears loaded control
	task automatic t_hardware_reset_n();
		check("ctrl", {3'h0, ctrl_q}, 8'h00);
		set_ctrl(1'h1, 1'h1, 1'h1, LIUSP_TXSRC_RCLK);
		@(posedge core_clk) hardware_reset_n <= 1'h0;
		@(posedge core_clk) hardware_reset_n <= 1'h1;
		#1 check("ctrl", {3'h0, ctrl_q}, 8'h00);
	endtask

	// Receive pins follow only the selected edge
	task automatic t_rx();
		for (int s = 0; s < 2; s++) begin
			set_ctrl(s[0], 1'h0, 1'h0, LIUSP_TXSRC_PIN);
			nxt_sym = 3'h5;
			edge_to(0, ~s[0]);
			check("rx", {rx_positive_data, rx_negative_data}, 8'h02);
			nxt_sym = 3'h2;
			edge_to(0, s[0]);
			check("rx", {rx_positive_data, rx_negative_data}, 8'h02);
			edge_to(0, ~s[0]);
			check("rx", {rx_positive_data, rx_negative_data}, 8'h01);
		end
	endtask

	// NRZ data on positive pin, error pulse on negative pin
	task automatic t_nrz();
		set_ctrl(1'h0, 1'h0, 1'h1, LIUSP_TXSRC_PIN);
		nxt_sym = 3'h5;
		edge_to(0, 1'h1);
		check("nrz", {rx_positive_data, rx_negative_data}, 8'h03);
		nxt_sym = 3'h6;
		edge_to(0, 1'h0);
		edge_to(0, 1'h1);
		check("nrz", {rx_positive_data, rx_negative_data}, 8'h02);
	endtask

	// Serial input and output on the same selected edge
	task automatic t_serial();
		for (int s = 0; s < 2; s++) begin
			@(posedge core_clk) begin
				input_edge_select <= s[0];
				output_edge_select <= ~s[0];
			end
			{nxt_sdi, nxt_sob} = 2'h3;
			edge_to(2, ~s[0]);
			check("sp", {n_sp[1:0], sp_bit, serial_port_data_out}, 8'h07);
			{nxt_sdi, nxt_sob} = 2'h0;
			edge_to(2, s[0]);
			check("sp", {n_sp[1:0], sp_bit, serial_port_data_out}, 8'h03);
			edge_to(2, ~s[0]);
			check("sp", {n_sp[1:0], sp_bit, serial_port_data_out}, 8'h04);
		end
	endtask

	// Transmit pins sampled on the selected edge of the framer clock
	task automatic t_tx();
		int k;
		for (int s = 0; s < 2; s++) begin
			set_ctrl(1'h0, s[0], 1'h0, LIUSP_TXSRC_PIN);
			@(posedge core_clk) run <= 1'h1;
			for (int n = 0; n < 4; n++) begin
				k = 0;
				do begin
					@(posedge core_clk) #1;
					k++;
				end while (tx_strobe_q !== 1'h1 && k < 40);
				if (k == 40) begin
					bad_count++;
					print_verdict();
				end
				check("tx", {tx_pos_q, tx_neg_q, transmit_clock_in},
					{tx_positive_data, tx_negative_data, s[0]});
			end
			@(posedge core_clk) run <= 1'h0;
		end
	endtask

	// Internal transmit clock sources
	task automatic t_src();
		int hits;
		for (int i = 0; i < 2; i++) begin
			set_ctrl(1'h0, 1'h0, 1'h0, i ? LIUSP_TXSRC_MCLK : LIUSP_TXSRC_RCLK);
			for (int j = 0; j < 2; j++) begin
				hits = 0;
				repeat (2) begin
					edge_to(j, ~clks[j]);
					hits += n_tx;
				end
				check("src", hits[7:0], {7'h0, i == j});
			end
		end
	endtask

	// Test input floats every receive and serial pin output
	task automatic t_tri();
		for (int s = 1; s >= 0; s--) begin
			@(posedge core_clk) tristate_test <= s[0];
			repeat (2) @(posedge core_clk);
			#1 check("oe", {rx_positive_data_oe_n, rx_negative_data_oe_n,
				serial_port_data_out_oe_n}, s[0] ? 8'h07 : 8'h00);
		end
	endtask

	// Main sequence
	initial begin
		nxt_sym = 3'h0;
		{nxt_sdi, nxt_sob} = 2'h0;
		@(posedge core_clk);
		@(posedge core_clk) rst_n <= 1'h1;
		@(posedge core_clk) #1;
		t_hardware_reset_n();
		$display("reset test done");
		t_rx();
		$display("receive test done");
		t_nrz();
		$display("nrz test done");
		t_serial();
		$display("serial test done");
		t_tx();
		$display("transmit test done");
		t_src();
		$display("source test done");
		t_tri();
		$display("tristate test done");
		print_verdict();
	end
endmodule // testbench
